// ===== hw/insn_decoder_params.svh
`ifndef INSN_DECODER_PARAMS_SVH
`define INSN_DECODER_PARAMS_SVH
// word and field geometry
`define IW_BITS     14
`define IMM8_BITS   8
`define IMM9_BITS   9
`define IMM12_BITS  12
`define REG_BITS    7
`define BITPOS_BITS 3
`define SEL_BITS    4
`define PC_BITS     11
// fixed opcode words
`define OP_NOP      14'h0000
`define OP_STANDBY  14'h0001
`define OP_WDT      14'h0002
`define OP_TMODE_W  14'h0003
`define OP_IRQ_ON   14'h0004
`define OP_RET      14'h0010
`define OP_RETURN_FROM_HANDLER    14'h0011
`define OP_DAA      14'h0012
`define OP_IRQ_OFF  14'h0013
`define OP_TMODE_R  14'h0014
`define OP_CLRA     14'h0200
`define OP_SWINT    14'h0210
`define OP_TABLE    14'h0211
`define OP_CCALL    14'h0212
`define OP_CJUMP    14'h0213
// cycle counts
`define CYC_ONE     2'h1
`define CYC_TWO     2'h2
`define CYC_THREE   2'h3
`endif

// ===== hw/insn_decoder_pkg.sv
package insn_decoder_pkg;
  typedef enum logic [5:0] {
    OP_NOP, OP_STANDBY, OP_WDT_RESTART, OP_TMODE_WR, OP_TMODE_RD,
    OP_PORT_WR, OP_PORT_RD, OP_SFR_WR, OP_SFR_RD, OP_IRQ_ON, OP_IRQ_OFF,
    OP_RET, OP_RETURN_FROM_HANDLER, OP_RETLIT, OP_DAA, OP_MOVAR, OP_MOVR, OP_CLRA, OP_CLRR,
    OP_SWINT, OP_TABLE, OP_CCALL, OP_CJUMP,
    OP_ADD, OP_SUB, OP_INC, OP_DEC, OP_COM, OP_AND, OP_IOR, OP_XOR,
    OP_RR, OP_RL, OP_SWAP, OP_INCSZ, OP_DECSZ, OP_ADC, OP_SBC, OP_CMP,
    OP_MOVI, OP_ANDI, OP_IORI, OP_XORI, OP_ADDI, OP_ADCI, OP_SUBI, OP_SBCI,
    OP_CALL, OP_GOTO, OP_BCLR, OP_BSET, OP_BTSC, OP_BTSS, OP_LONG_CALL, OP_LONG_JUMP,
    OP_ILLEGAL
  } op_e;

  typedef struct packed {
    logic carry;
    logic halfCarry;
    logic zero;
    logic timeout;
    logic sleepEntered;
  } flag_mask_s;

  typedef struct packed {
    op_e        op;
    logic [1:0] cycles;      // base cycles; skip ops may add one
    logic       maySkip;
    logic       destReg;     // 1: result back to register
    logic       pushReturn;
    logic       loadPc;
    flag_mask_s flags;
    logic       irqEnSet;
    logic       irqEnClr;
    logic [6:0] regAddr;
    logic [2:0] bitPos;
    logic [3:0] sel;
    logic [11:0] imm;
    logic       valid;
  } decode_s;

  typedef enum logic [1:0] {
    ST_ISSUE = 2'b00,
    ST_HOLD  = 2'b01
  } seq_e;
endpackage

// ===== hw/insn_field_decode.sv
`timescale 1ns/1ps
`include "insn_decoder_params.svh"
// pure opcode classification of a word
module insn_field_decode
  import insn_decoder_pkg::*;
(
  // word in
  input  wire logic [`IW_BITS-1:0] word,
  // class out
  output op_e                      op
);
  wire [1:0] pre = word[13:12];
  wire [3:0] sub = word[11:8];
  wire [7:0] lo  = word[7:0];

  always_comb begin
    op = OP_ILLEGAL;
    unique case (pre)
      2'h0: begin
        if (sub == 4'h0) begin
          // dedicated words first, then field access
          unique case (lo)
            8'h00: op = OP_NOP;
            8'h01: op = OP_STANDBY;
            8'h02: op = OP_WDT_RESTART;
            8'h03: op = OP_TMODE_WR;
            8'h04: op = OP_IRQ_ON;
            8'h10: op = OP_RET;
            8'h11: op = OP_RETURN_FROM_HANDLER;
            8'h12: op = OP_DAA;
            8'h13: op = OP_IRQ_OFF;
            8'h14: op = OP_TMODE_RD;
            default: begin
              if (lo[7]) op = OP_MOVAR;
              else if (lo[7:4] == 4'h0) op = OP_PORT_WR;
              else if (lo[7:4] == 4'h1) op = OP_PORT_RD;
              else if (lo[7:4] == 4'h2) op = OP_SFR_WR;
              else if (lo[7:4] == 4'h3) op = OP_SFR_RD;
            end
          endcase
        end else if (sub == 4'h1) op = OP_MOVR;
        else if (sub == 4'h2) begin
          if (lo[7]) op = OP_CLRR;
          else if (lo == 8'h00) op = OP_CLRA;
          else if (lo == 8'h10) op = OP_SWINT;
          else if (lo == 8'h11) op = OP_TABLE;
          else if (lo == 8'h12) op = OP_CCALL;
          else if (lo == 8'h13) op = OP_CJUMP;
        end else begin
          // register-file alu group
          unique case (sub)
            4'h3: op = OP_ADD;
            4'h4: op = OP_SUB;
            4'h5: op = OP_INC;
            4'h6: op = OP_DEC;
            4'h7: op = OP_COM;
            4'h8: op = OP_AND;
            4'h9: op = OP_IOR;
            4'ha: op = OP_XOR;
            4'hb: op = OP_RR;
            4'hc: op = OP_RL;
            4'hd: op = OP_SWAP;
            4'he: op = OP_INCSZ;
            default: op = OP_DECSZ;
          endcase
        end
      end
      2'h1: begin
        unique case (sub)
          4'h0: op = OP_RETLIT;
          4'h1: op = OP_MOVI;
          4'h2: op = OP_ANDI;
          4'h3: op = OP_IORI;
          4'h4: op = OP_XORI;
          4'h5: op = OP_ADDI;
          4'h6: op = OP_ADCI;
          4'h7: op = OP_SUBI;
          4'h8: op = OP_SBCI;
          4'h9: op = OP_CALL;
          4'ha, 4'hb: op = OP_GOTO;
          4'hc: op = OP_ADC;
          4'hd: op = OP_SBC;
          4'he: op = lo[7] ? OP_CMP : OP_ILLEGAL;
          default: op = OP_ILLEGAL;
        endcase
      end
      2'h2: begin
        // bit group
        unique case (sub[3:2])
          2'h3: op = OP_BCLR;
          2'h2: op = OP_BSET;
          2'h1: op = OP_BTSC;
          default: op = OP_BTSS;
        endcase
      end
      default: op = word[11] ? OP_LONG_JUMP : OP_LONG_CALL;
    endcase
  end
endmodule

// ===== hw/insn_decoder.sv
`timescale 1ns/1ps
`include "insn_decoder_params.svh"
// Behaviour
// - fixed word 0001 is standby entry, one cycle, touches timeout and sleep flags.
// - watchdog restart word is one cycle, touches timeout and sleep flags.
// - timer mode write and read words are one cycle, no flags.
// - low nibble picks port control register; write or read in one cycle.
// - four-bit field picks special function register; write or read, one cycle.
// - return with literal and plain return each take two cycles.
// - table read loads table high byte and work register in two cycles.
// - destination bit 0 selects work register, 1 selects the addressed register.
// - register alu group decodes with destination bit and 7-bit address, one cycle.
// - add/sub set carry, half, zero; logic zero only; rotates carry; swap none.
// - increment/decrement skip ops take one or two cycles, change no flags.
// - register add with carry and subtract with borrow set carry, half, zero.
// - immediate ops under prefix 01 with codes 0001 to 1000, one cycle.
// - immediate arithmetic sets carry, half, zero; logic zero; move no flags.
// - bit clear, set, test-clear, test-set use 3-bit position, no flags.
// - bit tests take two cycles when skipping, discarding the fetched word.
// - irq off clears, irq on sets global enable in one cycle; handler return sets it in two.
// - compare subtracts work register from register, sets carry and zero only.
// - short call loads 8-bit immediate, clears bit 8, bank from status, two cycles.
// - computed call and jump load pc from pointer high and work register.
module insn_decoder
  import insn_decoder_pkg::*;
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  // fetched word from program memory
  input  wire logic [`IW_BITS-1:0]   fetchWord,
  input  wire logic                  fetchValid,
  // condition feedback from the datapath
  input  wire logic                  skipCond,
  // decoded result
  output decode_s                    dec,
  output logic                       busy,
  output logic                       discard
);
  // ===========================================================
  // classification
  op_e opNow;

  insn_field_decode u_class (
    .word (fetchWord),
    .op   (opNow)
  );

  // ===========================================================
  // per-op attributes
  function automatic flag_mask_s flagsOf(input op_e o);
    flag_mask_s f;
    f = '0;
    unique case (o)
      OP_STANDBY, OP_WDT_RESTART: begin
        f.timeout = 1'b1;
        f.sleepEntered = 1'b1;
      end
      OP_ADD, OP_SUB, OP_ADC, OP_SBC,
      OP_ADDI, OP_ADCI, OP_SUBI, OP_SBCI: begin
        f.carry = 1'b1;
        f.halfCarry = 1'b1;
        f.zero = 1'b1;
      end
      OP_INC, OP_DEC, OP_COM, OP_MOVR, OP_AND, OP_IOR, OP_XOR,
      OP_ANDI, OP_IORI, OP_XORI, OP_CLRA, OP_CLRR: f.zero = 1'b1;
      OP_RR, OP_RL, OP_DAA: f.carry = 1'b1;
      OP_CMP: begin
        f.carry = 1'b1;
        f.zero = 1'b1;
      end
      default: f = '0;                                    // swap, skips, bit ops
    endcase
    return f;
  endfunction

  function automatic logic [1:0] cyclesOf(input op_e o);
    logic [1:0] c;
    c = `CYC_ONE;
    unique case (o)
      OP_RET, OP_RETURN_FROM_HANDLER, OP_RETLIT, OP_TABLE, OP_CCALL, OP_CJUMP,
      OP_CALL, OP_GOTO, OP_LONG_CALL, OP_LONG_JUMP: c = `CYC_TWO;
      OP_SWINT: c = `CYC_THREE;
      default: c = `CYC_ONE;
    endcase
    return c;
  endfunction

  // combinational view of the fetched word
  wire        isSkip   = (opNow == OP_INCSZ) || (opNow == OP_DECSZ) ||
                         (opNow == OP_BTSC) || (opNow == OP_BTSS);
  wire        isDest   = (fetchWord[13:12] == 2'h0) && (fetchWord[11:8] != 4'h0) &&
                         (fetchWord[11:8] != 4'h2) && fetchWord[7];
  wire        isDestB  = (fetchWord[13:12] == 2'h1) && (opNow == OP_ADC || opNow == OP_SBC)
                         && fetchWord[7];
  wire        regWrOnly = (opNow == OP_MOVAR) || (opNow == OP_CLRR) || (opNow == OP_BCLR)
                         || (opNow == OP_BSET);
  wire        pushNow  = (opNow == OP_CALL) || (opNow == OP_LONG_CALL) || (opNow == OP_CCALL);
  wire        jumpNow  = pushNow || (opNow == OP_GOTO) || (opNow == OP_LONG_JUMP) ||
                         (opNow == OP_CJUMP) || (opNow == OP_RET) || (opNow == OP_RETURN_FROM_HANDLER) ||
                         (opNow == OP_RETLIT) || (opNow == OP_SWINT);
  wire [11:0] immNow   = (opNow == OP_LONG_CALL || opNow == OP_LONG_JUMP) ? fetchWord[11:0] :
                         (opNow == OP_GOTO) ? {3'h0, fetchWord[8:0]} :
                         {4'h0, fetchWord[7:0]};

  decode_s decNow;
  always_comb begin
    decNow = '0;
    decNow.op = opNow;
    decNow.cycles = cyclesOf(opNow);
    decNow.maySkip = isSkip;
    decNow.destReg = isDest || isDestB || regWrOnly;
    decNow.pushReturn = pushNow;
    decNow.loadPc = jumpNow;
    decNow.flags = flagsOf(opNow);
    decNow.irqEnSet = (opNow == OP_IRQ_ON) || (opNow == OP_RETURN_FROM_HANDLER);
    decNow.irqEnClr = (opNow == OP_IRQ_OFF);
    decNow.regAddr = fetchWord[6:0];
    decNow.bitPos = fetchWord[9:7];
    decNow.sel = fetchWord[3:0];
    decNow.imm = immNow;
    decNow.valid = fetchValid;
  end

  // ===========================================================
  // issue/hold sequencer for multi-cycle words
  seq_e       state_r, state_nxt;
  logic [1:0] left_r, left_nxt;

  wire issue = (state_r == ST_ISSUE) && fetchValid;
  wire needHold = issue && (decNow.cycles != `CYC_ONE);

  always_comb begin
    state_nxt = state_r;
    left_nxt = left_r;
    unique case (state_r)
      ST_ISSUE: if (needHold) begin
        state_nxt = ST_HOLD;
        left_nxt = decNow.cycles - `CYC_ONE;
      end
      ST_HOLD: begin
        left_nxt = left_r - 2'h1;
        if (left_r == `CYC_ONE) state_nxt = ST_ISSUE;
      end
    endcase
  end

  // register the decode and the sequencer
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_ISSUE;
      left_r <= 2'h0;
      dec <= '0;
      busy <= 1'b0;
      discard <= 1'b0;
    end else begin
      state_r <= state_nxt;
      left_r <= left_nxt;
      busy <= (state_nxt == ST_HOLD);
      if (issue) dec <= decNow;
      else dec.valid <= 1'b0;
      // skip ops: condition arrives with execution, next word becomes a nop
      discard <= dec.valid && dec.maySkip && skipCond;
    end
  end

  // ===========================================================
  // checks
  a_standby_flags: assert property (@(posedge mclk) disable iff (!rst_b)
    issue && fetchWord == `OP_STANDBY |=> dec.flags.timeout && dec.flags.sleepEntered
      && dec.cycles == `CYC_ONE)
    else $error("standby decode wrong");
  a_wdt_flags: assert property (@(posedge mclk) disable iff (!rst_b)
    issue && fetchWord == `OP_WDT |=> dec.op == OP_WDT_RESTART && dec.flags.sleepEntered)
    else $error("watchdog restart decode wrong");
  a_tmode_noflags: assert property (@(posedge mclk) disable iff (!rst_b)
    issue && (fetchWord == `OP_TMODE_W || fetchWord == `OP_TMODE_R) |=> dec.flags == '0)
    else $error("timer mode ops touched flags");
  a_priority_fixed: assert property (@(posedge mclk) disable iff (!rst_b)
    issue && fetchWord == `OP_IRQ_ON |=> dec.op == OP_IRQ_ON && dec.irqEnSet)
    else $error("port access beat fixed word");
  a_two_cycle_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    needHold && decNow.cycles == `CYC_TWO |=> busy ##1 !busy)
    else $error("two-cycle op hold wrong");
  a_table_two: assert property (@(posedge mclk) disable iff (!rst_b)
    issue && fetchWord == `OP_TABLE |=> dec.cycles == `CYC_TWO && dec.op == OP_TABLE)
    else $error("table read cycles wrong");
  a_skip_discard: assert property (@(posedge mclk) disable iff (!rst_b)
    dec.valid && dec.maySkip && skipCond |=> discard)
    else $error("skip did not discard next word");
  a_skip_noflags: assert property (@(posedge mclk) disable iff (!rst_b)
    dec.valid && dec.maySkip |-> dec.flags == '0)
    else $error("skip op changes flags");
  a_irq_off: assert property (@(posedge mclk) disable iff (!rst_b)
    issue && fetchWord == `OP_IRQ_OFF |=> dec.irqEnClr && !dec.irqEnSet)
    else $error("irq off decode wrong");
  a_long_imm: assert property (@(posedge mclk) disable iff (!rst_b)
    issue && fetchWord[13:12] == 2'h3 |=> dec.imm == $past(fetchWord[11:0]) && dec.loadPc)
    else $error("long branch immediate wrong");
  a_cmp_flags: assert property (@(posedge mclk) disable iff (!rst_b)
    dec.valid && dec.op == OP_CMP |-> dec.flags.carry && dec.flags.zero && !dec.flags.halfCarry
      && !dec.destReg)
    else $error("compare flags wrong");
endmodule

// ===== dv/prog_mem_model.sv
`timescale 1ns/1ps
// ==========================================================
// program memory side of the decoder
module prog_mem_model (
  // clock and decoder state
  input  wire logic        mclk,
  input  wire logic        busy,
  // word to the decoder
  output logic [13:0]      fetchWord,
  output logic             fetchValid
);
  // extra idle cycles before a word, to act as a slow memory
  int gapCycles = 0;

  // idle bus at time zero
  initial begin
    fetchWord  = 14'h0000;
    fetchValid = 1'b0;
  end

  // offer a word and hold it while the decoder is busy
  // once taken the bus shows the inverse, so a stale word never looks current
  task automatic send(input logic [13:0] w);
    int n;
    n = 0;
    repeat (gapCycles) @(posedge mclk);
    @(posedge mclk);
    fetchWord  <= w;
    fetchValid <= 1'b1;
    do begin
      @(negedge mclk);
      n++;
    end while (busy && n < 8);
    @(posedge mclk);
    fetchWord  <= ~w;
    fetchValid <= 1'b0;
  endtask
endmodule

// ===== dv/tb_insn_decoder.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the instruction decoder
module tb_insn_decoder
  import insn_decoder_pkg::*;
;
  typedef struct packed {
    logic [13:0] w;
    op_e         op;
    logic [1:0]  c;
    logic [4:0]  f;
    logic [1:0]  irq;
  } fix_s;

  // fixed words: flags are {carry, half, zero, timeout, sleep}, irq is {set, clear}
  localparam fix_s FIX[11] = '{
    '{14'h0001, OP_STANDBY, 2'h1, 5'h03, 2'h0}, '{14'h0002, OP_WDT_RESTART, 2'h1, 5'h03, 2'h0},
    '{14'h0003, OP_TMODE_WR, 2'h1, 5'h00, 2'h0}, '{14'h0014, OP_TMODE_RD, 2'h1, 5'h00, 2'h0},
    '{14'h0004, OP_IRQ_ON, 2'h1, 5'h00, 2'h2}, '{14'h0013, OP_IRQ_OFF, 2'h1, 5'h00, 2'h1},
    '{14'h0011, OP_RETURN_FROM_HANDLER, 2'h2, 5'h00, 2'h2}, '{14'h0010, OP_RET, 2'h2, 5'h00, 2'h0},
    '{14'h0211, OP_TABLE, 2'h2, 5'h00, 2'h0}, '{14'h0212, OP_CCALL, 2'h2, 5'h00, 2'h0},
    '{14'h0213, OP_CJUMP, 2'h2, 5'h00, 2'h0}};
  localparam logic [5:0] RC[15] = '{6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a,
                                    6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h1c, 6'h1d};
  localparam op_e RO[15] = '{OP_ADD, OP_SUB, OP_INC, OP_DEC, OP_COM, OP_AND, OP_IOR, OP_XOR,
                             OP_RR, OP_RL, OP_SWAP, OP_INCSZ, OP_DECSZ, OP_ADC, OP_SBC};
  localparam logic [4:0] RF[15] = '{5'h1c, 5'h1c, 5'h04, 5'h04, 5'h04, 5'h04, 5'h04, 5'h04,
                                    5'h10, 5'h10, 5'h00, 5'h00, 5'h00, 5'h1c, 5'h1c};
  localparam op_e IO[10] = '{OP_RETLIT, OP_MOVI, OP_ANDI, OP_IORI, OP_XORI,
                             OP_ADDI, OP_ADCI, OP_SUBI, OP_SBCI, OP_CALL};
  localparam logic [4:0] IF[10] = '{5'h00, 5'h00, 5'h04, 5'h04, 5'h04, 5'h1c, 5'h1c, 5'h1c, 5'h1c, 5'h00};
  localparam op_e BO[4] = '{OP_BCLR, OP_BSET, OP_BTSC, OP_BTSS};

  logic        mclk;
  logic        rst_b;
  logic        skipCond;
  logic        busy;
  logic        discard;
  logic        fetchValid;
  logic [13:0] fetchWord;
  decode_s     dec;
  int          badCount = 0;
  int          checkCount = 0;
  int          cycles = 0;

  // ==========================================================
  // clock, design and memory model
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  insn_decoder u_dut (.mclk(mclk), .rst_b(rst_b), .fetchWord(fetchWord), .fetchValid(fetchValid),
                      .skipCond(skipCond), .dec(dec), .busy(busy), .discard(discard));
  prog_mem_model u_mem (.mclk(mclk), .busy(busy), .fetchWord(fetchWord), .fetchValid(fetchValid));

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // issue one word, judge the decode one cycle later and the skip flag after that
  task automatic run(input logic [13:0] w, input op_e op, input logic [1:0] cyc, input logic [4:0] fl,
                     input logic sk);
    u_mem.send(w);
    skipCond <= sk;
    @(negedge mclk);
    chk(dec.valid, 1'b1);
    chk(dec.op, op);
    chk(dec.cycles, cyc);
    chk(dec.flags, fl);
    chk(busy, cyc > 2'h1);
    @(negedge mclk);
    chk(discard, sk);
  endtask

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_fixed();
    foreach (FIX[i]) begin
      run(FIX[i].w, FIX[i].op, FIX[i].c, FIX[i].f, 1'b0);
      chk({dec.irqEnSet, dec.irqEnClr}, FIX[i].irq);
      if (i >= 9) begin
        chk({dec.pushReturn, dec.loadPc}, (i == 9) ? 2'h3 : 2'h1);
      end
    end
    run(14'h0005, OP_PORT_WR, 2'h1, 5'h00, 1'b0);
    chk(dec.sel, 4'h5);
    run(14'h001f, OP_PORT_RD, 2'h1, 5'h00, 1'b0);
    chk(dec.sel, 4'hf);
    run(14'h002a, OP_SFR_WR, 2'h1, 5'h00, 1'b0);
    chk(dec.sel, 4'ha);
    run(14'h0039, OP_SFR_RD, 2'h1, 5'h00, 1'b0);
    chk(dec.sel, 4'h9);
    // fixed words sitting inside the port field must still win
    run(14'h0000, OP_NOP, 2'h1, 5'h00, 1'b0);
    run(14'h0012, OP_DAA, 2'h1, 5'h10, 1'b0);
    run(14'h0085, OP_MOVAR, 2'h1, 5'h00, 1'b0);
    chk(dec.destReg, 1'b1);
    run({6'h01, 1'b1, 7'h05}, OP_MOVR, 2'h1, 5'h04, 1'b0);
    chk(dec.destReg, 1'b1);
    run(14'h0200, OP_CLRA, 2'h1, 5'h04, 1'b0);
    $display("fixed words done");
  endtask

  task automatic t_regalu();
    logic [6:0] a;
    for (int i = 0; i < 15; i++) begin
      for (int d = 0; d < 2; d++) begin
        a = d[0] ? 7'h7f : 7'h00;
        run({RC[i], d[0], a}, RO[i], 2'h1, RF[i], 1'b0);
        chk(dec.destReg, d[0]);
        chk(dec.regAddr, a);
      end
    end
    run({6'h1e, 1'b1, 7'h2a}, OP_CMP, 2'h1, 5'h14, 1'b0);
    run({6'h0e, 1'b1, 7'h10}, OP_INCSZ, 2'h1, 5'h00, 1'b1);
    run({6'h0f, 1'b0, 7'h11}, OP_DECSZ, 2'h1, 5'h00, 1'b1);
    $display("register group done");
  endtask

  // slow memory for the immediate ops here, so the decoder also sees gaps between words
  task automatic t_imm();
    logic [7:0] v;
    u_mem.gapCycles = 2;
    for (int i = 0; i < 10; i++) begin
      v = i[0] ? 8'hff : 8'h01;
      run({2'b01, i[3:0], v}, IO[i], (i == 0 || i == 9) ? 2'h2 : 2'h1, IF[i], 1'b0);
      chk(dec.imm, {4'h0, v});
    end
    chk(dec.pushReturn, 1'b1);
    u_mem.gapCycles = 0;
    run({5'b01101, 9'h1a5}, OP_GOTO, 2'h2, 5'h00, 1'b0);
    chk(dec.imm, 12'h1a5);
    run({3'b110, 11'h5a5}, OP_LONG_CALL, 2'h2, 5'h00, 1'b0);
    chk(dec.imm[10:0], 11'h5a5);
    run({3'b111, 11'h2aa}, OP_LONG_JUMP, 2'h2, 5'h00, 1'b0);
    chk(dec.imm[10:0], 11'h2aa);
    $display("immediate and branch done");
  endtask

  // tests alternate skip taken and not taken, bit set and clear never skip
  task automatic t_bits();
    logic [1:0] sub;
    for (int i = 0; i < 4; i++) begin
      sub = 2'h3 - i[1:0];
      for (int b = 0; b < 8; b++) begin
        run({2'b10, sub, b[2:0], 7'h7f}, BO[i], 2'h1, 5'h00, (i > 1) && b[0]);
        chk(dec.bitPos, b[2:0]);
        chk(dec.regAddr, 7'h7f);
      end
    end
    $display("bit group done");
  endtask

  // ==========================================================
  // hang guard and main sequence
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles > 4000) begin
      badCount++;
      giveVerdict();
    end
  end

  initial begin
    rst_b = 1'b0;
    skipCond = 1'b0;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    t_fixed();
    t_regalu();
    t_imm();
    t_bits();
    giveVerdict();
  end
endmodule
